// ==== verilog/rts_device.sv ====
// slave end: serial protocol engine, register map and SRAM, on the link clock
`timescale 1ns/1ps
`default_nettype none
module rts_device (
  // link
  rts_bus_if.device bus,
  input wire logic i_clk_link,
  input wire logic i_resetn,
  // user side, system clock domain
  input wire logic i_clk_sys,
  input wire logic i_alarm0,
  input wire logic i_alarm1,
  input wire logic i_sqw,
  output logic o_busy
);
  // the device runs on a free link-side sampling clock; scl/sda are sampled
  typedef struct packed {
    logic [2:0] scl_sh;
    logic [2:0] sda_sh;
    logic scl_f;
    logic sda_f;
    rts_pkg::rts_dev_state_t st;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic [7:0] ptr;
    logic rd;
    logic drive_lo;
    logic in_ack;
    logic busy;
    logic [7:0] ctrl;
  } rts_dev_s_t;
  rts_dev_s_t s_q, s_d;
  logic [7:0] mem_q [rts_pkg::MEM_WORDS];
  logic mem_we;
  logic [7:0] mem_wa;
  logic [7:0] mem_wd;

  function automatic logic in_map(input logic [7:0] a);
    in_map = (a <= rts_pkg::SRAM_LAST);
  endfunction : in_map

  // out-of-range locations (above SRAM_LAST) read as zero
  function automatic logic [7:0] rd_byte(input logic [7:0] a, input logic [7:0] c);
    if (!in_map(a)) begin
      rd_byte = rts_pkg::ZERO_BYTE;
    end else if (a == rts_pkg::CTRL_ADDR) begin
      rd_byte = c;
    end else begin
      rd_byte = mem_q[a[6:0]];
    end
  endfunction : rd_byte

  always_comb begin
    logic rise;
    logic fall;
    logic start;
    logic stop;
    rise = 1'b0;
    fall = 1'b0;
    start = 1'b0;
    stop = 1'b0;
    s_d = s_q;
    mem_we = 1'b0;
    mem_wa = s_q.ptr;
    mem_wd = s_q.sh;
    s_d.scl_sh = {s_q.scl_sh[1:0], bus.scl};
    s_d.sda_sh = {s_q.sda_sh[1:0], bus.sda};
    if (s_q.scl_sh[2] == s_q.scl_sh[1]) begin
      s_d.scl_f = s_q.scl_sh[1];
    end
    if (s_q.sda_sh[2] == s_q.sda_sh[1]) begin
      s_d.sda_f = s_q.sda_sh[1];
    end
    rise = s_d.scl_f & ~s_q.scl_f;
    fall = ~s_d.scl_f & s_q.scl_f;
    start = s_q.scl_f & s_d.scl_f & s_q.sda_f & ~s_d.sda_f;
    stop = s_q.scl_f & s_d.scl_f & ~s_q.sda_f & s_d.sda_f;
    if (start) begin
      s_d.st = rts_pkg::DS_CTRL;
      s_d.cnt = '0;
      s_d.drive_lo = 1'b0;
      s_d.in_ack = 1'b0;
      s_d.busy = 1'b1;
    end else if (stop) begin
      s_d.st = rts_pkg::DS_IDLE;
      s_d.drive_lo = 1'b0;
      s_d.in_ack = 1'b0;
      s_d.busy = 1'b0;
    end else if (s_q.st != rts_pkg::DS_IDLE && s_q.st != rts_pkg::DS_IGNORE) begin
      if (rise && !s_q.in_ack) begin
        // data only read while clock high, so mid-low changes are harmless
        s_d.sh = {s_q.sh[6:0], s_q.sda_f};
        s_d.cnt = s_q.cnt + 4'h1;
      end
      if (rise && s_q.in_ack && s_q.st == rts_pkg::DS_RDACK) begin
        // master no-ack ends the read; stay released until stop
        if (s_q.sda_f) begin
          s_d.st = rts_pkg::DS_IGNORE;
        end else begin
          s_d.st = rts_pkg::DS_RD;
        end
      end
      if (fall) begin
        if (s_q.in_ack) begin
          s_d.in_ack = 1'b0;
          s_d.drive_lo = 1'b0;
          s_d.cnt = '0;
          if (s_q.st == rts_pkg::DS_RD) begin
            s_d.sh = rd_byte(s_q.ptr, s_q.ctrl);
            s_d.drive_lo = ~s_d.sh[7];
          end
        end else if (s_q.cnt == rts_pkg::ACK_BIT) begin
          s_d.in_ack = 1'b1;
          unique case (s_q.st)
            rts_pkg::DS_CTRL: begin
              if (s_q.sh[7:1] == rts_pkg::DEV_TYPE_ID) begin
                s_d.drive_lo = 1'b1;
                s_d.rd = s_q.sh[0];
                s_d.st = s_q.sh[0] ? rts_pkg::DS_RD : rts_pkg::DS_ADDR;
              end else begin
                s_d.st = rts_pkg::DS_IGNORE;
                s_d.in_ack = 1'b0;
              end
            end
            rts_pkg::DS_ADDR: begin
              s_d.ptr = s_q.sh;
              if (in_map(s_q.sh)) begin
                s_d.drive_lo = 1'b1;
                s_d.st = rts_pkg::DS_WR;
              end else begin
                s_d.st = rts_pkg::DS_IGNORE;
                s_d.in_ack = 1'b0;
              end
            end
            rts_pkg::DS_WR: begin
              // stored as given, no range checks on time fields
              if (in_map(s_q.ptr)) begin
                mem_we = 1'b1;
                if (s_q.ptr == rts_pkg::CTRL_ADDR) begin
                  s_d.ctrl = s_q.sh;
                end
                s_d.drive_lo = 1'b1;
              end
              s_d.ptr = s_q.ptr + 8'h01;
            end
            rts_pkg::DS_RD: begin
              s_d.st = rts_pkg::DS_RDACK;
              s_d.ptr = s_q.ptr + 8'h01;
              s_d.drive_lo = 1'b0;
            end
            default: begin
              s_d.in_ack = 1'b0;
            end
          endcase
        end else if (s_q.st == rts_pkg::DS_RD) begin
          // sh shifts on every rise outside the ack bit, so the next bit is always at the top
          s_d.drive_lo = ~s_q.sh[7];
        end
      end
    end
  end

  always_ff @(posedge i_clk_link) begin
    if (!i_resetn) begin
      s_q <= '{scl_sh: 3'h7, sda_sh: 3'h7, scl_f: 1'b1, sda_f: 1'b1,
               st: rts_pkg::DS_IDLE, sh: 8'h00, cnt: 4'h0, ptr: 8'h00,
               rd: 1'b0, drive_lo: 1'b0, in_ack: 1'b0, busy: 1'b0,
               ctrl: rts_pkg::CTRL_RESET};
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge i_clk_link) begin
    if (mem_we) begin
      mem_q[mem_wa[6:0]] <= mem_wd;
    end
  end

  // pulled low only; the pull-up makes the high level
  assign bus.sda_s_o = 1'b0;
  assign bus.sda_s_oe = s_q.drive_lo;

  // multi-function output in system domain: alarm, square wave or level
  typedef struct packed {
    logic [1:0] busy_sync;
    logic [2:0] c_out;
    logic [2:0] c_sqwe;
    logic [2:0] c_a0;
    logic [2:0] c_a1;
    logic mfo_lo;
    logic busy;
  } rts_sys_s_t;
  rts_sys_s_t y_q, y_d;

  always_comb begin
    logic lvl;
    lvl = 1'b1;
    y_d = y_q;
    y_d.busy_sync = {y_q.busy_sync[0], s_q.busy};
    y_d.busy = y_q.busy_sync[1];
    y_d.c_out = {y_q.c_out[1:0], s_q.ctrl[rts_pkg::CTRL_OUT_BIT]};
    y_d.c_sqwe = {y_q.c_sqwe[1:0], s_q.ctrl[rts_pkg::CTRL_SQWE_BIT]};
    y_d.c_a0 = {y_q.c_a0[1:0], s_q.ctrl[rts_pkg::CTRL_ALM0_BIT]};
    y_d.c_a1 = {y_q.c_a1[1:0], s_q.ctrl[rts_pkg::CTRL_ALM1_BIT]};
    if (y_q.c_sqwe[2]) begin
      lvl = i_sqw;
    end else if (y_q.c_a0[2] | y_q.c_a1[2]) begin
      lvl = ~((y_q.c_a0[2] & i_alarm0) | (y_q.c_a1[2] & i_alarm1));
    end else begin
      lvl = y_q.c_out[2];
    end
    y_d.mfo_lo = ~lvl;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      y_q <= '0;
    end else begin
      y_q <= y_d;
    end
  end

  assign bus.mfo_oe = y_q.mfo_lo;
  assign o_busy = y_q.busy;
endmodule : rts_device
`default_nettype wire

// ==== verilog/rts_pkg.sv ====
// shared constants for the two-wire clock/calendar slave port and its master
package rts_pkg;
  localparam logic [6:0] DEV_TYPE_ID = 7'h55; // arbitrary neutral identifier
  localparam logic [7:0] RTC_FIRST = 8'h00;
  localparam logic [7:0] RTC_LAST = 8'h1F;
  localparam logic [7:0] TIME_LAST = 8'h06;
  localparam logic [7:0] CFG_FIRST = 8'h07;
  localparam logic [7:0] CFG_LAST = 8'h09;
  localparam logic [7:0] ALM0_FIRST = 8'h0A;
  localparam logic [7:0] ALM0_LAST = 8'h10;
  localparam logic [7:0] ALM1_FIRST = 8'h11;
  localparam logic [7:0] ALM1_LAST = 8'h17;
  localparam logic [7:0] TSTAMP_FIRST = 8'h18;
  localparam logic [7:0] SRAM_FIRST = 8'h20;
  localparam logic [7:0] SRAM_LAST = 8'h5F;
  localparam int MEM_WORDS = 96;
  localparam logic [7:0] CTRL_ADDR = 8'h07;
  localparam int CTRL_OUT_BIT = 7;
  localparam int CTRL_SQWE_BIT = 6;
  localparam int CTRL_ALM0_BIT = 4;
  localparam int CTRL_ALM1_BIT = 5;
  localparam logic [7:0] CTRL_RESET = 8'h80;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [3:0] LAST_BIT = 4'h7;
  localparam logic [3:0] ACK_BIT = 4'h8;
  // master divides the system clock by 2*(HALF_DIV+1) for the serial clock
  localparam logic [7:0] HALF_DIV = 8'h40;
  localparam int SYNC_STAGES = 3;
  typedef enum logic [2:0] {
    DS_IDLE = 3'b000,
    DS_CTRL = 3'b001,
    DS_ADDR = 3'b010,
    DS_WR = 3'b011,
    DS_RD = 3'b100,
    DS_RDACK = 3'b101,
    DS_IGNORE = 3'b110
  } rts_dev_state_t;
  typedef enum logic [3:0] {
    MS_IDLE = 4'b0000,
    MS_START = 4'b0001,
    MS_BIT_LO = 4'b0010,
    MS_BIT_HI = 4'b0011,
    MS_ACK_LO = 4'b0100,
    MS_ACK_HI = 4'b0101,
    MS_STOP_LO = 4'b0110,
    MS_STOP_HI = 4'b0111,
    MS_STOP_END = 4'b1000,
    MS_RSTART = 4'b1001
  } rts_mst_state_t;
endpackage : rts_pkg

// ==== verilog/rts_bus_if.sv ====
// two-wire link between the master end and the clock/calendar slave end
`timescale 1ns/1ps
`default_nettype none
interface rts_bus_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic mfo_oe;
  // open-drain wires with pull-up
  wire scl = ~(scl_oe & ~scl_o);
  wire sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));
  modport master (
    output scl_o, scl_oe, sda_m_o, sda_m_oe,
    input scl, sda
  );
  modport device (
    output sda_s_o, sda_s_oe, mfo_oe,
    input scl, sda
  );
endinterface : rts_bus_if
`default_nettype wire

// ==== verilog/rts_master.sv ====
// master end: generates serial clock, start/stop, one byte per request
`timescale 1ns/1ps
`default_nettype none
module rts_master (
  rts_bus_if.master bus,
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // request: i_start issues a start first, i_stop a stop after
  input wire logic i_req,
  input wire logic i_start,
  input wire logic i_stop,
  input wire logic i_read,
  input wire logic i_ack_last,
  input wire logic [7:0] i_wdata,
  // answer
  output logic o_busy,
  output logic o_done,
  output logic o_nack,
  output logic [7:0] o_rdata
);
  typedef struct packed {
    logic [2:0] scl_sh;
    logic [2:0] sda_sh;
    logic sda_f;
    rts_pkg::rts_mst_state_t st;
    logic [7:0] div;
    logic [7:0] sh;
    logic [3:0] cnt;
    logic rd;
    logic ackout;
    logic stop;
    logic scl_lo;
    logic sda_lo;
    logic busy;
    logic done;
    logic nack;
    logic [7:0] rdata;
  } rts_mst_s_t;
  rts_mst_s_t m_q, m_d;

  always_comb begin
    logic tick;
    tick = (m_q.div == rts_pkg::HALF_DIV);
    m_d = m_q;
    m_d.done = 1'b0;
    m_d.scl_sh = {m_q.scl_sh[1:0], bus.scl};
    m_d.sda_sh = {m_q.sda_sh[1:0], bus.sda};
    if (m_q.sda_sh[2] == m_q.sda_sh[1]) begin
      m_d.sda_f = m_q.sda_sh[1];
    end
    m_d.div = tick ? 8'h00 : m_q.div + 8'h01;
    unique case (m_q.st)
      rts_pkg::MS_IDLE: begin
        m_d.div = 8'h00;
        // only begin on an idle bus, both lines high
        // own clock held low means the transfer is still ours (repeated start)
        if (i_req && !m_q.busy && (m_q.scl_lo || (m_q.scl_sh[2] && m_q.sda_f))) begin
          m_d.busy = 1'b1;
          m_d.sh = i_read ? 8'hFF : i_wdata;
          m_d.rd = i_read;
          m_d.ackout = i_ack_last;
          m_d.stop = i_stop;
          m_d.cnt = '0;
          m_d.st = i_start ? rts_pkg::MS_START : rts_pkg::MS_BIT_LO;
          m_d.sda_lo = i_start ? 1'b0 : m_q.sda_lo;
        end
      end
      rts_pkg::MS_START: if (tick) begin
        if (m_q.scl_lo) begin
          // repeated start: data released first, then the clock
          m_d.scl_lo = 1'b0;
        end else begin
          m_d.sda_lo = 1'b1;
          m_d.st = rts_pkg::MS_RSTART;
        end
      end
      rts_pkg::MS_RSTART: if (tick) begin
        m_d.scl_lo = 1'b1;
        m_d.st = rts_pkg::MS_BIT_LO;
      end
      rts_pkg::MS_BIT_LO: if (tick) begin
        m_d.scl_lo = 1'b0;
        m_d.st = rts_pkg::MS_BIT_HI;
      end else if (m_q.div == 8'h01) begin
        m_d.sda_lo = ~m_q.sh[7];
      end
      rts_pkg::MS_BIT_HI: if (tick) begin
        m_d.scl_lo = 1'b1;
        m_d.sh = {m_q.sh[6:0], m_q.sda_f};
        m_d.cnt = m_q.cnt + 4'h1;
        m_d.st = (m_q.cnt == rts_pkg::LAST_BIT) ? rts_pkg::MS_ACK_LO : rts_pkg::MS_BIT_LO;
      end
      rts_pkg::MS_ACK_LO: if (tick) begin
        m_d.scl_lo = 1'b0;
        m_d.st = rts_pkg::MS_ACK_HI;
      end else if (m_q.div == 8'h01) begin
        m_d.sda_lo = m_q.rd & m_q.ackout;
      end
      rts_pkg::MS_ACK_HI: if (tick) begin
        m_d.scl_lo = 1'b1;
        m_d.nack = m_q.rd ? 1'b0 : m_q.sda_f;
        m_d.rdata = m_q.sh;
        m_d.st = m_q.stop ? rts_pkg::MS_STOP_LO : rts_pkg::MS_IDLE;
        m_d.busy = m_q.stop;
        m_d.done = ~m_q.stop;
      end
      rts_pkg::MS_STOP_LO: if (tick) begin
        m_d.sda_lo = 1'b1;
        m_d.scl_lo = 1'b0;
        m_d.st = rts_pkg::MS_STOP_HI;
      end
      rts_pkg::MS_STOP_HI: if (tick) begin
        m_d.sda_lo = 1'b0;
        m_d.st = rts_pkg::MS_STOP_END;
      end
      rts_pkg::MS_STOP_END: if (tick) begin
        m_d.busy = 1'b0;
        m_d.done = 1'b1;
        m_d.st = rts_pkg::MS_IDLE;
      end
      default: begin
        m_d.st = rts_pkg::MS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      m_q <= '{scl_sh: 3'h7, sda_sh: 3'h7, sda_f: 1'b1, st: rts_pkg::MS_IDLE,
               div: 8'h00, sh: 8'h00, cnt: 4'h0, rd: 1'b0, ackout: 1'b0,
               stop: 1'b0, scl_lo: 1'b0, sda_lo: 1'b0, busy: 1'b0, done: 1'b0,
               nack: 1'b0, rdata: 8'h00};
    end else begin
      m_q <= m_d;
    end
  end

  assign bus.scl_o = 1'b0;
  assign bus.scl_oe = m_q.scl_lo;
  assign bus.sda_m_o = 1'b0;
  assign bus.sda_m_oe = m_q.sda_lo;
  assign o_busy = m_q.busy;
  assign o_done = m_q.done;
  assign o_nack = m_q.nack;
  assign o_rdata = m_q.rdata;
endmodule : rts_master
`default_nettype wire

// ==== sim/rts_assertions.sv ====
// concurrent checks on the two-wire link between master and slave ends
`timescale 1ns/1ps
`default_nettype none
module rts_assertions (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // link signals
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_o,
  input wire logic sda_m_o,
  input wire logic sda_s_o,
  input wire logic sda_s_oe
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);
  sequence s_start;
    $fell(sda) && scl;
  endsequence
  sequence s_stop;
    $rose(sda) && scl;
  endsequence
  chk_dev_no_high: assert property (!sda_s_o)
    else $error("slave drives data high");
  chk_mst_drain_only: assert property (!scl_o && !sda_m_o)
    else $error("master drives a line high");
  chk_dev_change_low: assert property ($changed(sda_s_oe) |-> !scl)
    else $error("slave changed data while clock high");
  chk_scl_high_phase: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  chk_scl_low_phase: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");
  chk_ack_held_low: assert property ($rose(scl) && sda_s_oe |-> (sda_s_oe && !sda) [*8])
    else $error("slave low level not held through high phase");
  chk_start_hold: assert property (s_start |-> scl [*4])
    else $error("clock fell too soon after start");
  chk_stop_setup: assert property (s_stop |-> $past(scl, 4))
    else $error("stop without clock high setup");
  chk_stop_release: assert property (s_stop |=> !sda_s_oe [*8])
    else $error("slave pulled data after stop");
endmodule : rts_assertions
`default_nettype wire

// ==== sim/rtcc_sram_i2c_slave_port_test.sv ====
// self-checking bench: master and slave ends joined over the two-wire link
`timescale 1ns/1ps
`default_nettype none
module rtcc_sram_i2c_slave_port_test;
  logic clk_sys = 1'b0;
  logic clk_link = 1'b0;
  logic resetn = 1'b0;
  logic req = 1'b0, start = 1'b0, stop = 1'b0, rd = 1'b0, ack_last = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic busy, done, nack, dev_busy, got_nack;
  logic [7:0] rdata, got, b0, b1;
  int errors = 0;
  int tests_run = 0;
  always #12.5 clk_sys = ~clk_sys;
  // odd offset keeps link edges off the system edges
  initial begin
    #3.3;
    forever #7.5 clk_link = ~clk_link;
  end
  rts_bus_if bus ();
  rts_master i_rts_master (.bus(bus.master), .i_clk_sys(clk_sys), .i_resetn(resetn),
    .i_req(req), .i_start(start), .i_stop(stop), .i_read(rd), .i_ack_last(ack_last),
    .i_wdata(wdata), .o_busy(busy), .o_done(done), .o_nack(nack), .o_rdata(rdata));
  rts_device i_rts_device (.bus(bus.device), .i_clk_link(clk_link), .i_resetn(resetn),
    .i_clk_sys(clk_sys), .i_alarm0(1'b0), .i_alarm1(1'b0), .i_sqw(1'b0), .o_busy(dev_busy));
  rts_assertions i_rts_assertions (.i_clk_sys(clk_sys), .i_resetn(resetn), .scl(bus.scl),
    .sda(bus.sda), .scl_o(bus.scl_o), .sda_m_o(bus.sda_m_o), .sda_s_o(bus.sda_s_o),
    .sda_s_oe(bus.sda_s_oe));
  task automatic results;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  task automatic check(input logic ok, input string what);
    tests_run++;
    if (ok !== 1'b1) begin
      errors++;
      $display("mismatch at %0t: %s", $time, what);
    end
  endtask : check
  // one byte; req held until the master shows busy, so it is never lost
  task automatic xfer(input logic s, p, r, a, input logic [7:0] d);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    req <= 1'b1;
    start <= s;
    stop <= p;
    rd <= r;
    ack_last <= a;
    wdata <= d;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (busy !== 1'b1 && n < 400);
    @(negedge clk_sys);
    req <= 1'b0;
    while (done !== 1'b1 && n < 5000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 5000) begin
      errors++;
      $display("mismatch at %0t: byte timeout", $time);
      results();
    end
    got = rdata;
    got_nack = nack;
  endtask : xfer
  task automatic settle;
    int n;
    n = 0;
    while (dev_busy !== 1'b0 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    check(dev_busy === 1'b0, "slave busy after stop");
  endtask : settle
  task automatic ctrl_addr(input logic [7:0] addr);
    xfer(1'b1, 1'b0, 1'b0, 1'b0, {rts_pkg::DEV_TYPE_ID, 1'b0});
    check(got_nack === 1'b0, "control byte not acked");
    check(dev_busy === 1'b1, "slave idle after start");
    xfer(1'b0, 1'b0, 1'b0, 1'b0, addr);
    check(got_nack === 1'b0, "address not acked");
  endtask : ctrl_addr
  task automatic wr(input logic [7:0] addr, d0, d1);
    ctrl_addr(addr);
    xfer(1'b0, 1'b0, 1'b0, 1'b0, d0);
    check(got_nack === 1'b0, "data byte not acked");
    xfer(1'b0, 1'b1, 1'b0, 1'b0, d1);
    settle();
  endtask : wr
  // repeated start switches direction; last byte not acked
  task automatic rd2(input logic [7:0] addr);
    ctrl_addr(addr);
    xfer(1'b1, 1'b0, 1'b0, 1'b0, {rts_pkg::DEV_TYPE_ID, 1'b1});
    check(got_nack === 1'b0, "read control not acked");
    xfer(1'b0, 1'b0, 1'b1, 1'b1, 8'h00);
    b0 = got;
    xfer(1'b0, 1'b1, 1'b1, 1'b0, 8'h00);
    b1 = got;
    settle();
  endtask : rd2
  task automatic t_sram;
    wr(8'h20, 8'hA5, 8'h3C);
    rd2(8'h20);
    check(b0 === 8'hA5 && b1 === 8'h3C, "sram readback");
  endtask : t_sram
  task automatic t_time;
    wr(8'h00, 8'hFF, 8'h9A);
    rd2(8'h00);
    check(b0 === 8'hFF && b1 === 8'h9A, "time registers");
  endtask : t_time
  task automatic t_map_edge;
    wr(8'h5E, 8'h11, 8'h77);
    rd2(8'h5F);
    check(b0 === 8'h77, "last sram byte");
    check(b1 === 8'h00, "beyond map not zero");
  endtask : t_map_edge
  task automatic t_bad_id;
    xfer(1'b1, 1'b1, 1'b0, 1'b0, {rts_pkg::DEV_TYPE_ID ^ 7'h01, 1'b0});
    check(got_nack === 1'b1, "foreign identifier acked");
    settle();
  endtask : t_bad_id
  task automatic t_bad_addr;
    xfer(1'b1, 1'b0, 1'b0, 1'b0, {rts_pkg::DEV_TYPE_ID, 1'b0});
    xfer(1'b0, 1'b1, 1'b0, 1'b0, 8'h60);
    check(got_nack === 1'b1, "out of range address acked");
    settle();
  endtask : t_bad_addr
  task automatic t_mfo;
    int n;
    check(bus.mfo_oe === 1'b0, "output pulled low after reset");
    wr(8'h07, 8'h00, 8'h00);
    n = 0;
    while (bus.mfo_oe !== 1'b1 && n < 100) begin
      @(posedge clk_sys);
      n++;
    end
    check(bus.mfo_oe === 1'b1, "output level bit ignored");
  endtask : t_mfo
  initial begin
    repeat (8) @(negedge clk_sys);
    resetn <= 1'b1;
    repeat (8) @(negedge clk_sys);
    t_sram();
    t_time();
    t_map_edge();
    t_bad_id();
    t_bad_addr();
    t_mfo();
    results();
  end
endmodule : rtcc_sram_i2c_slave_port_test
`default_nettype wire
